// *** pwr_save_pkg.sv ***
// constants and types shared by the power-save sequencer files
package pwr_save_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;

  // control register fields
  localparam int unsigned CTL_RETAIN_BIT  = 0;
  localparam int unsigned CTL_STANDBY_BIT = 1;
  localparam int unsigned CTL_PDIS_LSB    = 8;
  localparam int unsigned PDIS_W          = 8;
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;

  // status register fields
  localparam int unsigned STS_STATE_LSB   = 0;
  localparam int unsigned STS_MODE_LSB    = 4;
  localparam int unsigned STS_LOCKOUT_BIT = 6;
  localparam int unsigned STS_RETAIN_BIT  = 7;

  // timing, system clock at 200 MHz
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned WAKE_BASE_NS    = 10400;
  localparam int unsigned RET_EXTRA_NS    = 10000;
  localparam int unsigned STBY_SAVE_NS    = 10000;
  // least times round up, the saving is a longest time and rounds down
  localparam int unsigned WAKE_BASE_CYC   = (WAKE_BASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RET_EXTRA_CYC   = (RET_EXTRA_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STBY_SAVE_CYC   = (STBY_SAVE_NS * CLK_MHZ) / 1000;
  localparam int unsigned WAKE_CNT_W      = 13;

  // low-power rc oscillator defaults (cycles of clock_i)
  localparam int unsigned OSC_DIV_DEFAULT      = 6452;
  localparam int unsigned OSC_STARTUP_DEFAULT  = 20000;
  localparam int unsigned OSC_CNT_W            = 16;
  localparam logic [1:0]  LOCK_TICKS_RUNNING   = 2'h1;
  localparam logic [1:0]  LOCK_TICKS_STOPPED   = 2'h2;

  // sleep variants: {retention_enable_bit, regulator_standby_bit}
  typedef enum logic [1:0] {
    MODE_SLEEP     = 2'b00,
    MODE_FAST_WAKE = 2'b01,
    MODE_RETENTION = 2'b10,
    MODE_FAST_RET  = 2'b11
  } sleep_mode_t;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_ENTER   = 3'b001,
    ST_IDLE    = 3'b010,
    ST_SLEEP   = 3'b011,
    ST_LOCKOUT = 3'b100,
    ST_WAKE    = 3'b101
  } pwr_state_t;

endpackage

// *** lockout_if.sv ***
// handshake between the sequencer and its retention lockout timer
`timescale 1ns/100ps
`default_nettype none
interface lockout_if;
  logic start;
  logic osc_running;
  logic done;
  modport ctrl  (output start, output osc_running, input done);
  modport timer (input start, input osc_running, output done);
endinterface
`default_nettype wire

// *** retention_lockout_timer.sv ***
// lockout timer paced by the low-power rc oscillator tick
`timescale 1ns/100ps
`default_nettype none
module retention_lockout_timer #(
  parameter logic [15:0] OSC_DIV     = 16'(pwr_save_pkg::OSC_DIV_DEFAULT),
  parameter logic [15:0] OSC_STARTUP = 16'(pwr_save_pkg::OSC_STARTUP_DEFAULT)
) (
  // clock and reset
  input  wire logic  clock_i,
  input  wire logic  rst_i,
  // sequencer side
  lockout_if.timer   lk
);

  typedef struct packed {
    logic [15:0] phase;
    logic [15:0] startup;
    logic [1:0]  ticks;
    logic        active;
    logic        done;
  } lock_state_t;

  lock_state_t r;
  lock_state_t next_r;
  logic        osc_tick;

  // one-cycle enable standing in for an oscillator period
  assign osc_tick = r.active && (r.startup == 16'h0000) && (r.phase == OSC_DIV - 16'h0001);

  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    if (lk.start)
    begin
      // one period when running, start-up plus two otherwise
      next_r.active  = 1'b1;
      next_r.phase   = 16'h0000;
      next_r.startup = lk.osc_running ? 16'h0000 : OSC_STARTUP;
      next_r.ticks   = lk.osc_running ? pwr_save_pkg::LOCK_TICKS_RUNNING
                                      : pwr_save_pkg::LOCK_TICKS_STOPPED;
    end
    else if (r.active)
    begin
      if (r.startup != 16'h0000)
      begin
        next_r.startup = r.startup - 16'h0001;
      end
      else if (osc_tick)
      begin
        next_r.phase = 16'h0000;
        next_r.ticks = r.ticks - 2'h1;
        if (r.ticks == 2'h1)
        begin
          next_r.active = 1'b0;
          next_r.done   = 1'b1;
        end
      end
      else
      begin
        next_r.phase = r.phase + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign lk.done = r.done;

endmodule // retention_lockout_timer
`default_nettype wire

// *** idle_sleep_sequencer.sv ***
// idle and sleep entry, wake-up and retention regulator sequencing
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module idle_sleep_sequencer #(
  parameter logic [15:0] OSC_DIV     = 16'(pwr_save_pkg::OSC_DIV_DEFAULT),
  parameter logic [15:0] OSC_STARTUP = 16'(pwr_save_pkg::OSC_STARTUP_DEFAULT)
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        write_i,
  input  wire logic        read_i,
  output logic      [15:0] rdata_o,
  // cpu core
  input  wire logic        power_save_instruction_i,
  input  wire logic        power_save_sleep_i,
  output logic             cpu_clock_en_o,
  output logic             wake_o,
  output logic             wake_isr_o,
  // wake and reset sources
  input  wire logic        irq_i,
  input  wire logic        por_i,
  input  wire logic        master_clear_pin_i,
  input  wire logic        other_reset_i,
  input  wire logic        watchdog_timer_timeout_i,
  // configuration
  input  wire logic        watchdog_timer_enable_i,
  input  wire logic        clock_fail_monitor_enable_i,
  input  wire logic        retention_config_fuse_i,
  // clock and power controls
  output logic             sys_clock_run_o,
  output logic      [7:0]  periph_clock_en_o,
  output logic             low_power_rc_osc_run_o,
  output logic             watchdog_timer_clear_o,
  output logic             retention_reg_en_o,
  output logic             bandgap_en_o
);

  typedef struct packed {
    pwr_save_pkg::pwr_state_t  state;
    pwr_save_pkg::sleep_mode_t mode;
    logic [15:0]               control;
    logic                      sleep_req;
    logic                      retain;
    logic                      deferred;
    logic                      irq_block;
    logic                      to_isr;
    logic [12:0]               wake_cnt;
    logic                      lock_start;
    logic [15:0]               rdata;
    logic                      cpu_clock_en;
    logic                      wake;
    logic                      wake_isr;
    logic                      sys_clock_run;
    logic [7:0]                periph_clock_en;
    logic                      osc_run;
    logic                      osc_was_on;
    logic                      dog_clear;
    logic                      ret_reg_en;
    logic                      bandgap_en;
  } seq_state_t;

  seq_state_t r;
  seq_state_t next_r;

  lockout_if lk ();

  retention_lockout_timer #(
    .OSC_DIV     (OSC_DIV),
    .OSC_STARTUP (OSC_STARTUP)
  ) u_lockout (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .lk      (lk)
  );

  assign lk.start       = r.lock_start;
  // lockout forces the oscillator on, so its earlier state is kept apart
  assign lk.osc_running = r.osc_was_on;

  // wake delay of each sleep variant
  function automatic logic [12:0] wake_delay(input pwr_save_pkg::sleep_mode_t m);
    logic [12:0] base;
    base = 13'(pwr_save_pkg::WAKE_BASE_CYC);
    unique case (m)
      pwr_save_pkg::MODE_SLEEP:     wake_delay = base;
      pwr_save_pkg::MODE_FAST_WAKE: wake_delay = base - 13'(pwr_save_pkg::STBY_SAVE_CYC);
      pwr_save_pkg::MODE_RETENTION: wake_delay = base + 13'(pwr_save_pkg::RET_EXTRA_CYC);
      pwr_save_pkg::MODE_FAST_RET:  wake_delay = base + 13'(pwr_save_pkg::RET_EXTRA_CYC)
                                                 - 13'(pwr_save_pkg::STBY_SAVE_CYC);
    endcase
  endfunction

  logic any_reset;
  logic irq_live;
  assign any_reset = por_i || master_clear_pin_i || other_reset_i;
  // an interrupt held since lockout does not count
  assign irq_live  = irq_i && !r.irq_block;

  always_comb
  begin
    next_r            = r;
    next_r.wake       = 1'b0;
    next_r.wake_isr   = 1'b0;
    next_r.dog_clear  = 1'b0;
    next_r.lock_start = 1'b0;
    next_r.rdata      = 16'h0000;

    if (write_i && addr_i == pwr_save_pkg::OFS_CONTROL)
    begin
      next_r.control = wdata_i;
    end
    if (read_i)
    begin
      unique case (addr_i)
        pwr_save_pkg::OFS_CONTROL: next_r.rdata = r.control;
        pwr_save_pkg::OFS_STATUS:
        begin
          next_r.rdata[pwr_save_pkg::STS_STATE_LSB +: 3]  = r.state;
          next_r.rdata[pwr_save_pkg::STS_MODE_LSB +: 2]   = r.mode;
          next_r.rdata[pwr_save_pkg::STS_LOCKOUT_BIT]     = (r.state == pwr_save_pkg::ST_LOCKOUT);
          next_r.rdata[pwr_save_pkg::STS_RETAIN_BIT]      = r.retain;
        end
        default:                   next_r.rdata = 16'h0000;
      endcase
    end

    unique case (r.state)
      pwr_save_pkg::ST_RUN:
      begin
        if (power_save_instruction_i)
        begin
          // control bits pick the sleep variant
          next_r.mode         = pwr_save_pkg::sleep_mode_t'(
                                  {r.control[pwr_save_pkg::CTL_RETAIN_BIT],
                                   r.control[pwr_save_pkg::CTL_STANDBY_BIT]});
          next_r.sleep_req    = power_save_sleep_i;
          next_r.deferred     = irq_i;
          next_r.cpu_clock_en = 1'b0;
          next_r.state        = pwr_save_pkg::ST_ENTER;
        end
      end
      pwr_save_pkg::ST_ENTER:
      begin
        next_r.deferred = r.deferred || irq_i;
        if (!r.sleep_req)
        begin
          // watchdog count cleared on idle entry
          next_r.dog_clear = 1'b1;
          next_r.state     = pwr_save_pkg::ST_IDLE;
        end
        // fuse programmed low and enable bit set
        else if (r.mode[1] && !retention_config_fuse_i)
        begin
          next_r.retain     = 1'b1;
          next_r.lock_start = 1'b1;
          // oscillator state from before lockout forced it on
          next_r.osc_was_on = r.osc_run;
          next_r.deferred   = 1'b0;
          next_r.irq_block  = irq_i;
          next_r.state      = pwr_save_pkg::ST_LOCKOUT;
        end
        else
        begin
          next_r.retain = 1'b0;
          next_r.state  = pwr_save_pkg::ST_SLEEP;
        end
      end
      pwr_save_pkg::ST_IDLE:
      begin
        // enabled interrupt, reset or timeout ends idle
        if (r.deferred || irq_i || any_reset || watchdog_timer_timeout_i)
        begin
          // cpu clock back on the next edge
          next_r.cpu_clock_en = 1'b1;
          next_r.wake         = 1'b1;
          next_r.wake_isr     = (r.deferred || irq_i) && !any_reset;
          next_r.deferred     = 1'b0;
          next_r.state        = pwr_save_pkg::ST_RUN;
        end
      end
      pwr_save_pkg::ST_LOCKOUT:
      begin
        // interrupts here are dropped and blocked
        next_r.irq_block = r.irq_block || irq_i;
        // only power-on or master clear exit early
        if (por_i || master_clear_pin_i)
        begin
          next_r.to_isr   = 1'b0;
          next_r.wake_cnt = wake_delay(r.mode);
          next_r.state    = pwr_save_pkg::ST_WAKE;
        end
        else if (lk.done)
        begin
          next_r.state = pwr_save_pkg::ST_SLEEP;
        end
      end
      pwr_save_pkg::ST_SLEEP:
      begin
        if (!irq_i)
        begin
          next_r.irq_block = 1'b0;
        end
        // every sleep wake source ends retention too
        if (r.deferred || irq_live || any_reset || watchdog_timer_timeout_i)
        begin
          next_r.to_isr   = (r.deferred || irq_live) && !any_reset;
          next_r.deferred = 1'b0;
          // a refused retention request wakes like the variant with the same standby bit and no retention
          next_r.wake_cnt = wake_delay(pwr_save_pkg::sleep_mode_t'({r.retain, r.mode[0]}));
          next_r.state    = pwr_save_pkg::ST_WAKE;
        end
      end
      pwr_save_pkg::ST_WAKE:
      begin
        if (r.wake_cnt <= 13'h0001)
        begin
          next_r.cpu_clock_en = 1'b1;
          next_r.wake         = 1'b1;
          next_r.wake_isr     = r.to_isr;
          next_r.retain       = 1'b0;
          next_r.irq_block    = 1'b0;
          next_r.state        = pwr_save_pkg::ST_RUN;
        end
        else
        begin
          next_r.wake_cnt = r.wake_cnt - 13'h0001;
        end
      end
      default:
      begin
        next_r.state = pwr_save_pkg::ST_RUN;
      end
    endcase

    // cpu clock stays off until wake
    // system clock only stops in sleep and lockout
    next_r.sys_clock_run = !(next_r.state == pwr_save_pkg::ST_SLEEP
                             || next_r.state == pwr_save_pkg::ST_LOCKOUT);
    next_r.periph_clock_en = next_r.sys_clock_run
                             ? ~r.control[pwr_save_pkg::CTL_PDIS_LSB +: pwr_save_pkg::PDIS_W]
                             : 8'h00;
    // oscillator kept for watchdog, monitor or lockout
    // lockout pacing needs the oscillator running
    next_r.osc_run = watchdog_timer_enable_i || clock_fail_monitor_enable_i
                     || next_r.state == pwr_save_pkg::ST_LOCKOUT;
    // regulator engaged only in sleep states
    next_r.ret_reg_en = next_r.retain && !next_r.sys_clock_run;
    // band gaps kept while standby is latched
    next_r.bandgap_en = next_r.sys_clock_run || next_r.mode[0];
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      r                 <= '0;
      r.state           <= pwr_save_pkg::ST_RUN;
      r.control         <= pwr_save_pkg::CONTROL_RESET;
      r.cpu_clock_en    <= 1'b1;
      r.sys_clock_run   <= 1'b1;
      r.periph_clock_en <= 8'hff;
      r.bandgap_en      <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rdata_o                = r.rdata;
  assign cpu_clock_en_o         = r.cpu_clock_en;
  assign wake_o                 = r.wake;
  assign wake_isr_o             = r.wake_isr;
  assign sys_clock_run_o        = r.sys_clock_run;
  assign periph_clock_en_o      = r.periph_clock_en;
  assign low_power_rc_osc_run_o = r.osc_run;
  assign watchdog_timer_clear_o = r.dog_clear;
  assign retention_reg_en_o     = r.ret_reg_en;
  assign bandgap_en_o           = r.bandgap_en;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_idle_cpu_off;
    r.state == pwr_save_pkg::ST_IDLE |-> !cpu_clock_en_o;
  endproperty
  a_idle_cpu_off: assert property (p_idle_cpu_off) else $error("cpu clock on in idle");

  property p_dog_clear;
    r.state == pwr_save_pkg::ST_ENTER && !r.sleep_req |=> watchdog_timer_clear_o;
  endproperty
  a_dog_clear: assert property (p_dog_clear) else $error("no watchdog clear on idle");

  property p_osc_kept;
    watchdog_timer_enable_i || clock_fail_monitor_enable_i |=> low_power_rc_osc_run_o;
  endproperty
  a_osc_kept: assert property (p_osc_kept) else $error("rc osc stopped");

  property p_idle_wake;
    r.state == pwr_save_pkg::ST_IDLE && irq_i |=> cpu_clock_en_o && wake_o && wake_isr_o;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");

  property p_defer;
    r.state == pwr_save_pkg::ST_RUN && power_save_instruction_i && irq_i && !power_save_sleep_i
      |=> !cpu_clock_en_o ##1 !cpu_clock_en_o ##1 cpu_clock_en_o;
  endproperty
  a_defer: assert property (p_defer) else $error("deferred interrupt mishandled");

  property p_ret_sleep_only;
    retention_reg_en_o |-> !sys_clock_run_o && r.mode[1];
  endproperty
  a_ret_sleep_only: assert property (p_ret_sleep_only) else $error("regulator out of sleep");

  property p_lock_por;
    r.state == pwr_save_pkg::ST_LOCKOUT && por_i |=> r.state == pwr_save_pkg::ST_WAKE;
  endproperty
  a_lock_por: assert property (p_lock_por) else $error("por ignored in lockout");

  property p_lock_mask;
    r.state == pwr_save_pkg::ST_LOCKOUT && !por_i && !master_clear_pin_i
      |=> r.state != pwr_save_pkg::ST_WAKE;
  endproperty
  a_lock_mask: assert property (p_lock_mask) else $error("lockout exited early");

  property p_ret_delay;
    $rose(r.state == pwr_save_pkg::ST_WAKE) && r.mode == pwr_save_pkg::MODE_RETENTION
      |-> !cpu_clock_en_o [*8];
  endproperty
  a_ret_delay: assert property (p_ret_delay) else $error("retention wake too fast");

  property p_mode_hold;
    r.state != pwr_save_pkg::ST_RUN |=> r.state == pwr_save_pkg::ST_RUN || $stable(r.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed while asleep");

  c_idle_trip: cover property (r.state == pwr_save_pkg::ST_IDLE ##1 wake_o);
  c_lockout:   cover property (r.state == pwr_save_pkg::ST_LOCKOUT ##1
                               r.state == pwr_save_pkg::ST_SLEEP);
  c_ret_wake:  cover property (r.retain && wake_o);

endmodule // idle_sleep_sequencer
`default_nettype wire

// *** cpu_core_model.sv ***
// cpu core model that issues the power-save instruction
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // bench requests
  input  wire logic go_i,
  input  wire logic go_sleep_i,
  // sequencer side
  input  wire logic wake_i,
  output logic      instr_o,
  output logic      sleep_o
);
  logic halted;

  // a halted core fetches nothing, so no new request before wake
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      halted  <= 1'b0;
      instr_o <= 1'b0;
      sleep_o <= 1'b0;
    end
    else
    begin
      instr_o <= go_i && !halted;
      if (go_i && !halted)
      begin
        halted  <= 1'b1;
        sleep_o <= go_sleep_i;
      end
      else if (wake_i)
        halted <= 1'b0;
    end
  end
endmodule // cpu_core_model
`default_nettype wire

// *** tb_idle_and_retention_sleep_control.sv ***
// self-checking bench for the idle and sleep sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_idle_and_retention_sleep_control;
  // short oscillator figures keep the lockout brief
  localparam logic [15:0] DIV     = 16'h0004;
  localparam logic [15:0] STARTUP = 16'h0006;
  logic        clock_i;
  logic        rst_i;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        write;
  logic        read;
  logic [15:0] rdata;
  logic        go;
  logic        go_sleep;
  logic        instr;
  logic        slp;
  logic        cpu_en;
  logic        wake;
  logic        wake_isr;
  logic [2:0]  src;
  logic        por;
  logic        mclear;
  logic        dog_en;
  logic        mon_en;
  logic        fuse;
  logic        sys_run;
  logic [7:0]  periph;
  logic        osc_run;
  logic        dog_clear;
  logic        ret_reg;
  logic        bandgap;
  logic [15:0] d;
  int          err_total;
  int          n_tests;
  int          cycles;
  int          osc_cnt;
  int          n;
  int          lat [4];

  idle_sleep_sequencer #(.OSC_DIV(DIV), .OSC_STARTUP(STARTUP)) idle_sleep_sequencer_inst (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .write_i(write),
    .read_i(read), .rdata_o(rdata), .power_save_instruction_i(instr),
    .power_save_sleep_i(slp), .cpu_clock_en_o(cpu_en), .wake_o(wake), .wake_isr_o(wake_isr),
    .irq_i(src[0]), .por_i(por), .master_clear_pin_i(mclear), .other_reset_i(src[1]),
    .watchdog_timer_timeout_i(src[2]), .watchdog_timer_enable_i(dog_en),
    .clock_fail_monitor_enable_i(mon_en), .retention_config_fuse_i(fuse),
    .sys_clock_run_o(sys_run), .periph_clock_en_o(periph), .low_power_rc_osc_run_o(osc_run),
    .watchdog_timer_clear_o(dog_clear), .retention_reg_en_o(ret_reg), .bandgap_en_o(bandgap));

  cpu_core_model cpu_core_model_inst (
    .clock_i(clock_i), .rst_i(rst_i), .go_i(go), .go_sleep_i(go_sleep),
    .wake_i(wake), .instr_o(instr), .sleep_o(slp));

  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    if (osc_run === 1'b1)
      osc_cnt <= osc_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    write <= 1'b1;
    @(posedge clock_i);
    write <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [15:0] v);
    addr <= a;
    read <= 1'b1;
    @(posedge clock_i);
    read <= 1'b0;
    #1 v = rdata;
    @(posedge clock_i);
  endtask

  // returns at the edge that takes the instruction
  task automatic enter(input logic s, input logic with_irq);
    go_sleep <= s;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    src[0] <= with_irq;
    @(posedge clock_i);
  endtask

  task automatic wait_run(output int k);
    k = 0;
    do
    begin
      @(posedge clock_i);
      #1 k++;
    end while (cpu_en !== 1'b1 && k < 5000);
  endtask

  task automatic reg_test();
    reg_read(pwr_save_pkg::OFS_CONTROL, d);
    check(d, pwr_save_pkg::CONTROL_RESET);
    reg_write(pwr_save_pkg::OFS_CONTROL, 16'h5a00);
    reg_write(pwr_save_pkg::OFS_STATUS, 16'hffff);
    reg_write(8'h08, 16'hffff);
    reg_read(pwr_save_pkg::OFS_CONTROL, d);
    #1 check(rdata, 16'h0000);
    check(d, 16'h5a00);
    check(16'(periph), 16'h00a5);
    @(posedge clock_i);
    reg_read(pwr_save_pkg::OFS_STATUS, d);
    check(d, 16'h0000);
    reg_read(8'h08, d);
    check(d, 16'h0000);
    $display("register test done");
  endtask

  // wake source s: 0 interrupt, 1 reset, 2 watchdog time-out
  task automatic idle_wake(input int s);
    {mon_en, dog_en} <= 2'(s);
    enter(1'b0, 1'b0);
    @(posedge clock_i);
    // the watchdog clear stands for one cycle only
    #1 check(16'(cpu_en), 16'h0000);
    check(16'(dog_clear), 16'h0001);
    @(posedge clock_i);
    src <= 3'(1 << s);
    #1 check(16'(sys_run), 16'h0001);
    check(16'(periph), 16'h00a5);
    check(16'(osc_run), 16'(s != 0));
    @(posedge clock_i);
    src <= 3'h0;
    #1 check(16'({cpu_en, wake}), 16'h0003);
    check(16'(wake_isr), 16'(s == 0));
    @(posedge clock_i);
    $display("idle wake test %0d done", s);
  endtask

  task automatic coincident();
    enter(1'b0, 1'b1);
    @(posedge clock_i);
    #1 check(16'(cpu_en), 16'h0000);
    @(posedge clock_i);
    #1 check(16'({cpu_en, wake}), 16'h0003);
    @(posedge clock_i);
    src[0] <= 1'b0;
    $display("coincident interrupt test done");
  endtask

  // m is {retention enable, regulator standby}
  task automatic sleep_run(input logic [1:0] m, output int k);
    reg_write(pwr_save_pkg::OFS_CONTROL, {14'h0000, m[0], m[1]});
    enter(1'b1, 1'b0);
    repeat (40) @(posedge clock_i);
    #1 check(16'(sys_run), 16'h0000);
    check(16'(periph), 16'h0000);
    check(16'(ret_reg), 16'(m[1] & ~fuse));
    check(16'(bandgap), 16'(m[0]));
    @(posedge clock_i);
    src[0] <= 1'b1;
    wait_run(k);
    check(16'({wake, wake_isr, ret_reg}), 16'h0006);
    @(posedge clock_i);
    src[0] <= 1'b0;
    $display("sleep variant %0d done", m);
  endtask

  task automatic lockout_test();
    dog_en <= 1'b0;
    reg_write(pwr_save_pkg::OFS_CONTROL, 16'h0001);
    osc_cnt = 0;
    enter(1'b1, 1'b1);
    repeat (2) @(posedge clock_i);
    reg_read(pwr_save_pkg::OFS_STATUS, d);
    check(16'(d[6:0]), 16'h0064);
    reg_write(pwr_save_pkg::OFS_CONTROL, 16'h0000);
    repeat (60) @(posedge clock_i);
    reg_read(pwr_save_pkg::OFS_STATUS, d);
    check(16'(d[5:4]), 16'h0002);
    check(16'(cpu_en), 16'h0000);
    // starting the timer and seeing it done cost one edge each
    check(16'(osc_cnt), 16'(STARTUP + 2 * DIV + 2));
    src[0] <= 1'b0;
    @(posedge clock_i);
    src[0] <= 1'b1;
    wait_run(n);
    check(16'({cpu_en, wake_isr}), 16'h0003);
    @(posedge clock_i);
    src[0] <= 1'b0;
    reg_write(pwr_save_pkg::OFS_CONTROL, 16'h0001);
    enter(1'b1, 1'b0);
    repeat (3) @(posedge clock_i);
    mclear <= 1'b1;
    @(posedge clock_i);
    mclear <= 1'b0;
    wait_run(n);
    check(16'({cpu_en, wake_isr}), 16'h0002);
    @(posedge clock_i);
    enter(1'b1, 1'b0);
    repeat (3) @(posedge clock_i);
    por <= 1'b1;
    @(posedge clock_i);
    por <= 1'b0;
    wait_run(n);
    check(16'({cpu_en, wake_isr}), 16'h0002);
    @(posedge clock_i);
    $display("lockout test done");
  endtask

  initial
  begin
    rst_i = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    write = 1'b0;
    read = 1'b0;
    go = 1'b0;
    go_sleep = 1'b0;
    src = 3'h0;
    por = 1'b0;
    mclear = 1'b0;
    dog_en = 1'b0;
    mon_en = 1'b0;
    fuse = 1'b0;
    err_total = 0;
    n_tests = 0;
    cycles = 0;
    osc_cnt = 0;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    reg_test();
    for (int s = 0; s < 3; s++)
      idle_wake(s);
    coincident();
    dog_en <= 1'b1;
    mon_en <= 1'b0;
    for (int m = 0; m < 4; m++)
      sleep_run(2'(m), lat[m]);
    check(16'(lat[2] - lat[0]), 16'(pwr_save_pkg::RET_EXTRA_CYC));
    check(16'(lat[0] - lat[1]), 16'(pwr_save_pkg::STBY_SAVE_CYC));
    check(16'(lat[2] - lat[3]), 16'(pwr_save_pkg::STBY_SAVE_CYC));
    fuse <= 1'b1;
    sleep_run(2'b10, n);
    check(16'(n), 16'(lat[0]));
    fuse <= 1'b0;
    lockout_test();
    tally_and_finish();
  end
endmodule // tb_idle_and_retention_sleep_control
`default_nettype wire
